// *** rtl/uerr_map.svh ***
// register offsets, field positions and reset values of the receive error block
`ifndef UERR_MAP_SVH
`define UERR_MAP_SVH
`define UERR_OFF_MODE 8'h00
`define UERR_OFF_STAT 8'h04
`define UERR_OFF_RXBUF 8'h08
`define UERR_OFF_BAUD 8'h0c
`define UERR_OFF_IRQ_ST 8'h10
`define UERR_OFF_IRQ_MSK 8'h14
`define UERR_MODE_PORT_EN 7
`define UERR_MODE_TX_EN 6
`define UERR_MODE_RX_EN 5
`define UERR_MODE_PAR_HI 4
`define UERR_MODE_PAR_LO 3
`define UERR_MODE_CHAR8 2
`define UERR_MODE_TX_SL 1
`define UERR_MODE_ERR_SEL 0
`define UERR_STAT_PE 2
`define UERR_STAT_FE 1
`define UERR_STAT_OV 0
`define UERR_IRQ_CMP 0
`define UERR_IRQ_ERR 1
`define UERR_MODE_RST 8'h04
`define UERR_STAT_RST 3'h0
`define UERR_BAUD_RST 16'h01b2
`endif

// *** rtl/uerr_pkg.sv ***
// types of the receive error block
package uerr_pkg;
    typedef enum logic [2:0] {
        UERR_IDLE = 3'b000,
        UERR_START = 3'b001,
        UERR_DATA = 3'b010,
        UERR_PAR = 3'b011,
        UERR_STOP = 3'b100
    } uerr_rx_state_t;
    typedef enum logic [1:0] {
        UERR_PAR_NONE = 2'b00,
        UERR_PAR_ZERO = 2'b01,
        UERR_PAR_ODD = 2'b10,
        UERR_PAR_EVEN = 2'b11
    } uerr_par_t;
endpackage

// *** rtl/uerr_rx_if.sv ***
// link between register side and receive shifter
`timescale 1ns/1ps
interface uerr_rx_if;
    logic enable;
    logic [15:0] divisor;
    logic char8;
    logic parity_en;
    logic done;
    logic [7:0] data;
    logic parity_bit;
    logic stop_bit;
    modport ctl (output enable, output divisor, output char8, output parity_en,
                 input done, input data, input parity_bit, input stop_bit);
    modport rx (input enable, input divisor, input char8, input parity_en,
                output done, output data, output parity_bit, output stop_bit);
endinterface

// *** rtl/uerr_sync.sv ***
// two flip-flop synchroniser for the receive pin
`timescale 1ns/1ps
module uerr_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** rtl/uerr_rx_shift.sv ***
// receive shifter: start check, data bits, optional parity, one stop bit
`timescale 1ns/1ps
module uerr_rx_shift (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rxd,
    uerr_rx_if.rx bus
);
    import uerr_pkg::*;
    uerr_rx_state_t state_q;
    logic [15:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] shf_q;
    logic par_q;
    logic stop_q;
    logic done_q;
    logic [2:0] last_bit;

    assign last_bit = bus.char8 ? 3'h7 : 3'h6;
    assign bus.done = done_q;
    assign bus.data = bus.char8 ? shf_q : {1'b0, shf_q[7:1]};
    assign bus.parity_bit = par_q;
    assign bus.stop_bit = stop_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= UERR_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            shf_q <= 8'h00;
            par_q <= 1'b0;
            stop_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!bus.enable) begin
                state_q <= UERR_IDLE;
            end else if (state_q != UERR_IDLE && cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end else begin
                case (state_q)
                    UERR_IDLE: begin
                        if (!rxd) begin
                            state_q <= UERR_START;
                            cnt_q <= {1'b0, bus.divisor[15:1]};
                        end
                    end
                    UERR_START: begin
                        bit_q <= 3'h0;
                        cnt_q <= bus.divisor;
                        state_q <= rxd ? UERR_IDLE : UERR_DATA;
                    end
                    UERR_DATA: begin
                        shf_q <= {rxd, shf_q[7:1]};
                        bit_q <= bit_q + 3'h1;
                        cnt_q <= bus.divisor;
                        if (bit_q == last_bit) begin
                            state_q <= bus.parity_en ? UERR_PAR : UERR_STOP;
                        end
                    end
                    UERR_PAR: begin
                        par_q <= rxd;
                        cnt_q <= bus.divisor;
                        state_q <= UERR_STOP;
                    end
                    // R3: one stop bit only
                    UERR_STOP: begin
                        stop_q <= rxd;
                        done_q <= 1'b1;
                        state_q <= UERR_IDLE;
                    end
                    default: begin
                        state_q <= UERR_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// *** rtl/uerr_top.sv ***
// receive error status block with register port and interrupts
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "uerr_map.svh"
// Function
// R1: select 0: error raises error interrupt only
// R2: select 1: error raises complete interrupt only
// R3: receiver checks exactly one stop bit
// R4: software stops transmitter before changing stop length
// R5: flags hold only the latest error
// R6: status read clears register to zero
// R7: software reads status before receive buffer
// R8: disabling port or receiver clears flags
// R9: parity bit2, framing bit1, overrun bit0
// R10: parity mismatch sets parity flag; the code checks parity in odd and even modes only, not in zero parity mode
// R11: status read-only, writes ignored
// R12: software avoids bit manipulation on status
// R13: low first stop bit sets framing flag
// R14: unread buffer: overrun, new character dropped
module uerr_top (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic RXD,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [31:0] RD_DATA,
    output logic IRQ,
    output logic RX_COMPLETE_IRQ,
    output logic RX_ERROR_IRQ
);
    import uerr_pkg::*;

    logic rxd_s;
    logic [7:0] mode_q;
    logic [2:0] err_q;
    logic [7:0] rxbuf_q;
    logic full_q;
    logic [15:0] baud_q;
    logic [1:0] ist_q;
    logic [1:0] imsk_q;
    logic [31:0] rd_q;
    logic irq_q;
    logic cmp_q;
    logic erirq_q;
    logic wr_mode;
    logic wr_baud;
    logic wr_ist;
    logic wr_imsk;
    logic rd_stat;
    logic rd_rxbuf;
    logic disable_clr;
    logic err_sel;
    uerr_par_t par_mode;
    logic exp_par;
    logic pe_now;
    logic fe_now;
    logic ov_now;
    logic any_err;
    logic [2:0] err_now;
    logic err_evt;

    uerr_rx_if rxi ();

    uerr_sync u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .d(RXD),
        .q(rxd_s)
    );

    uerr_rx_shift u_shift (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .rxd(rxd_s),
        .bus(rxi.rx)
    );

    // register decode
    assign wr_mode = WR_STB && ADDR == `UERR_OFF_MODE;
    assign wr_baud = WR_STB && ADDR == `UERR_OFF_BAUD;
    assign wr_ist = WR_STB && ADDR == `UERR_OFF_IRQ_ST;
    assign wr_imsk = WR_STB && ADDR == `UERR_OFF_IRQ_MSK;
    assign rd_stat = RD_STB && ADDR == `UERR_OFF_STAT;
    assign rd_rxbuf = RD_STB && ADDR == `UERR_OFF_RXBUF;
    assign disable_clr = wr_mode && !(WR_DATA[`UERR_MODE_PORT_EN] && WR_DATA[`UERR_MODE_RX_EN]);
    assign err_sel = mode_q[`UERR_MODE_ERR_SEL];
    assign par_mode = uerr_par_t'({mode_q[`UERR_MODE_PAR_HI], mode_q[`UERR_MODE_PAR_LO]});

    // R3: stop length not passed to receiver
    assign rxi.enable = mode_q[`UERR_MODE_PORT_EN] && mode_q[`UERR_MODE_RX_EN];
    assign rxi.divisor = baud_q;
    assign rxi.char8 = mode_q[`UERR_MODE_CHAR8];
    assign rxi.parity_en = par_mode != UERR_PAR_NONE;

    // R10: parity check by mode
    assign exp_par = (par_mode == UERR_PAR_ODD) ? ~^rxi.data : ^rxi.data;
    assign pe_now = (par_mode == UERR_PAR_ODD || par_mode == UERR_PAR_EVEN) && rxi.parity_bit != exp_par;
    // R13: first stop bit only
    assign fe_now = !rxi.stop_bit;
    // R14: overrun when buffer unread
    assign ov_now = full_q;
    assign any_err = pe_now || fe_now || ov_now;
    // R9: flag positions
    assign err_now = {pe_now, fe_now, ov_now};
    assign err_evt = rxi.done && any_err;

    // mode register, tx stop length kept but unused on receive
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            mode_q <= `UERR_MODE_RST;
        end else if (wr_mode) begin
            mode_q <= WR_DATA[7:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            baud_q <= `UERR_BAUD_RST;
        end else if (wr_baud) begin
            baud_q <= WR_DATA[15:0];
        end
    end

    // R5: latest error overwrites flags
    // R6: read clears, new error wins
    // R8: disable clears flags
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            err_q <= `UERR_STAT_RST;
        end else if (err_evt) begin
            err_q <= err_now;
        end else if (rd_stat || disable_clr) begin
            err_q <= `UERR_STAT_RST;
        end
    end

    // R14: keep old data on overrun
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rxbuf_q <= 8'h00;
            full_q <= 1'b0;
        end else if (rxi.done && !full_q) begin
            rxbuf_q <= rxi.data;
            full_q <= 1'b1;
        end else if (rd_rxbuf || disable_clr) begin
            full_q <= 1'b0;
        end
    end

    // R1: error interrupt when select is 0
    // R2: complete interrupt when select is 1
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cmp_q <= 1'b0;
            erirq_q <= 1'b0;
        end else begin
            cmp_q <= rxi.done && (!any_err || err_sel);
            erirq_q <= err_evt && !err_sel;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ist_q <= 2'b00;
            imsk_q <= 2'b00;
            irq_q <= 1'b0;
        end else begin
            ist_q <= (ist_q & ~(wr_ist ? WR_DATA[1:0] : 2'b00)) | {erirq_q, cmp_q};
            if (wr_imsk) begin
                imsk_q <= WR_DATA[1:0];
            end
            irq_q <= |(ist_q & imsk_q);
        end
    end

    // R11: status has no write path
    // R9: upper status bits read zero
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rd_q <= 32'h0000_0000;
        end else if (RD_STB) begin
            case (ADDR)
                `UERR_OFF_MODE: rd_q <= {24'h00_0000, mode_q};
                `UERR_OFF_STAT: rd_q <= {29'h0000_0000, err_q};
                `UERR_OFF_RXBUF: rd_q <= {24'h00_0000, rxbuf_q};
                `UERR_OFF_BAUD: rd_q <= {16'h0000, baud_q};
                `UERR_OFF_IRQ_ST: rd_q <= {30'h0000_0000, ist_q};
                `UERR_OFF_IRQ_MSK: rd_q <= {30'h0000_0000, imsk_q};
                default: rd_q <= 32'h0000_0000;
            endcase
        end else begin
            rd_q <= 32'h0000_0000;
        end
    end

    assign RD_DATA = rd_q;
    assign IRQ = irq_q;
    assign RX_COMPLETE_IRQ = cmp_q;
    assign RX_ERROR_IRQ = erirq_q;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    property p_r1;
        rxi.done && any_err && !err_sel |=> RX_ERROR_IRQ && !RX_COMPLETE_IRQ;
    endproperty
    a_r1: assert property (p_r1) else $error("error interrupt not chosen"); // R1

    property p_r2;
        rxi.done && any_err && err_sel |=> RX_COMPLETE_IRQ && !RX_ERROR_IRQ;
    endproperty
    a_r2: assert property (p_r2) else $error("complete interrupt not chosen"); // R2

    property p_r5;
        err_evt |=> err_q == $past(err_now);
    endproperty
    a_r5: assert property (p_r5) else $error("flags not latest error"); // R5

    property p_r6;
        rd_stat && !err_evt |=> err_q == 3'h0 && RD_DATA[2:0] == $past(err_q);
    endproperty
    a_r6: assert property (p_r6) else $error("status read did not clear"); // R6

    property p_r8;
        disable_clr && !err_evt |=> err_q == 3'h0 ##1 !rxi.done;
    endproperty
    a_r8: assert property (p_r8) else $error("disable did not clear flags"); // R8

    property p_r9;
        rd_stat |=> RD_DATA[31:3] == 29'h0000_0000 ##1 RD_DATA == 32'h0000_0000 || $past(RD_STB);
    endproperty
    a_r9: assert property (p_r9) else $error("status upper bits not zero"); // R9

    property p_r10;
        rxi.done && pe_now |=> err_q[`UERR_STAT_PE];
    endproperty
    a_r10: assert property (p_r10) else $error("parity error lost"); // R10

    property p_r11;
        WR_STB && ADDR == `UERR_OFF_STAT && !rxi.done |=> $stable(err_q);
    endproperty
    a_r11: assert property (p_r11) else $error("write changed status"); // R11

    property p_r13;
        rxi.done && !rxi.stop_bit |=> err_q[`UERR_STAT_FE];
    endproperty
    a_r13: assert property (p_r13) else $error("framing error lost"); // R13

    property p_r14;
        rxi.done && full_q |=> err_q[`UERR_STAT_OV] && $stable(rxbuf_q);
    endproperty
    a_r14: assert property (p_r14) else $error("overrun handled wrong"); // R14

    property p_irq;
        ist_q[`UERR_IRQ_ERR] && imsk_q[`UERR_IRQ_ERR] |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output missing");

    property p_clean;
        rxi.done && !any_err |=> RX_COMPLETE_IRQ && !RX_ERROR_IRQ;
    endproperty
    a_clean: assert property (p_clean) else $error("clean character not reported"); // R2

    property p_excl;
        RX_COMPLETE_IRQ |-> !RX_ERROR_IRQ;
    endproperty
    a_excl: assert property (p_excl) else $error("both receive events raised"); // R1

    property p_r6_set;
        rd_stat && err_evt |=> err_q == $past(err_now);
    endproperty
    a_r6_set: assert property (p_r6_set) else $error("read lost a new error"); // R6

    property p_r5_keep;
        rxi.done && !any_err && !rd_stat && !disable_clr |=> $stable(err_q);
    endproperty
    a_r5_keep: assert property (p_r5_keep) else $error("clean character changed flags"); // R5

    property p_r14_load;
        rxi.done && !full_q |=> full_q && rxbuf_q == $past(rxi.data);
    endproperty
    a_r14_load: assert property (p_r14_load) else $error("character not buffered"); // R14

    property p_r8_buf;
        disable_clr && !rxi.done |=> !full_q;
    endproperty
    a_r8_buf: assert property (p_r8_buf) else $error("disable kept buffer full"); // R8

    property p_rd_idle;
        !RD_STB |=> RD_DATA == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

    property p_irq_low;
        !(ist_q[`UERR_IRQ_CMP] && imsk_q[`UERR_IRQ_CMP]) && !(ist_q[`UERR_IRQ_ERR] && imsk_q[`UERR_IRQ_ERR]) |=> !IRQ;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt output without cause");

    c_clean: cover property (rxi.done && !any_err ##1 RX_COMPLETE_IRQ);
    c_overrun: cover property (rxi.done && full_q);
    c_err_sel: cover property (err_evt && err_sel);
    c_read_clear: cover property (rd_stat && err_q != 3'h0);
    c_err_irq: cover property (rxi.done && any_err && !err_sel ##1 RX_ERROR_IRQ);
endmodule

// *** verification/uerr_tx_model.sv ***
// remote serial transmitter driving the receive pin
`timescale 1ns/1ps
module uerr_tx_model #(
    parameter int DIV = 8
) (
    input wire logic clk,
    output logic rxd
);
    initial rxd = 1'b1;
    task automatic bit_out(input logic v);
        rxd <= v;
        repeat (DIV + 1) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] d, input logic c8, input logic [1:0] pm, input logic badp,
                        input logic stp);
        logic p;
        p = (^(c8 ? d : {1'b0, d[6:0]})) ^ (pm == 2'b10);
        if (pm == 2'b01) begin
            p = 1'b0;
        end
        @(posedge clk);
        bit_out(1'b0);
        for (int i = 0; i < (c8 ? 8 : 7); i++) begin
            bit_out(d[i]);
        end
        if (pm != 2'b00) begin
            bit_out(p ^ badp);
        end
        bit_out(stp);
        rxd <= 1'b1;
    endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the receive error block
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] d; logic c8; logic [1:0] pm; logic badp; logic stp; logic sl; logic sel;
        logic [2:0] st; logic cmp; logic err;
    } uerr_row_t;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic rxd;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rd_data;
    logic irq;
    logic cmp_irq;
    logic err_irq;
    int n_errors = 0;
    int checked = 0;
    int n_cmp = 0;
    int n_err = 0;
    int c0;
    int e0;
    logic [31:0] v;
    uerr_row_t rows [8];
    uerr_top u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .RXD(rxd), .ADDR(addr), .WR_DATA(wr_data),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .IRQ(irq), .RX_COMPLETE_IRQ(cmp_irq),
        .RX_ERROR_IRQ(err_irq));
    uerr_tx_model #(.DIV(8)) u_tx (.clk(clk_sys), .rxd(rxd));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (cmp_irq === 1'b1) n_cmp++;
        if (err_irq === 1'b1) n_err++;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic frame(input logic [7:0] d, input logic c8, input logic [1:0] pm, input logic badp,
                         input logic stp);
        u_tx.send(d, c8, pm, badp, stp);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    // transmitter stays disabled whenever stop length changes
    function automatic logic [31:0] mode(input logic [1:0] pm, input logic c8, input logic sl, input logic sel);
        return {24'h0, 1'b1, 1'b0, 1'b1, pm, c8, sl, sel};
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        results;
    end
    initial begin
        rows = '{
            '{8'ha5, 1'b1, 2'b00, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0},
            '{8'h3c, 1'b1, 2'b11, 1'b1, 1'b1, 1'b0, 1'b0, 3'h4, 1'b0, 1'b1},
            '{8'h5a, 1'b1, 2'b10, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0, 1'b1, 1'b0},
            '{8'h81, 1'b1, 2'b10, 1'b1, 1'b1, 1'b0, 1'b1, 3'h4, 1'b1, 1'b0},
            '{8'h0f, 1'b1, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2, 1'b0, 1'b1},
            '{8'hf0, 1'b1, 2'b01, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0},
            '{8'h55, 1'b0, 2'b11, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0},
            '{8'h6b, 1'b0, 2'b00, 1'b0, 1'b0, 1'b1, 1'b1, 3'h2, 1'b1, 1'b0}};
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h00);
        chk("mode_reset", v, 32'h04);
        rd(8'h04);
        chk("status_reset", v, 32'h0);
        rd(8'h0c);
        chk("baud_reset", v, 32'h1b2);
        wr(8'h0c, 32'h8);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(8'h00, mode(rows[i].pm, rows[i].c8, rows[i].sl, rows[i].sel));
            c0 = n_cmp;
            e0 = n_err;
            frame(rows[i].d, rows[i].c8, rows[i].pm, rows[i].badp, rows[i].stp);
            chk("complete_pulses", n_cmp - c0, rows[i].cmp);
            chk("error_pulses", n_err - e0, rows[i].err);
            rd(8'h04);
            chk("status", v, rows[i].st);
            rd(8'h04);
            chk("status_cleared", v, 32'h0);
            rd(8'h08);
            chk("buffer", v, rows[i].c8 ? rows[i].d : rows[i].d & 8'h7f);
        end
        $display("table test done");
        wr(8'h00, mode(2'b00, 1'b1, 1'b1, 1'b0));
        u_tx.send(8'h11, 1'b1, 2'b00, 1'b0, 1'b1);
        u_tx.send(8'h22, 1'b1, 2'b00, 1'b0, 1'b1);
        repeat (8) @(posedge clk_sys);
        rd(8'h04);
        chk("overrun_status", v, 32'h1);
        rd(8'h08);
        chk("overrun_buffer", v, 32'h11);
        $display("overrun test done");
        wr(8'h00, mode(2'b11, 1'b1, 1'b0, 1'b0));
        frame(8'h33, 1'b1, 2'b11, 1'b1, 1'b1);
        rd(8'h08);
        chk("buffer", v, 32'h33);
        frame(8'h44, 1'b1, 2'b11, 1'b0, 1'b0);
        rd(8'h04);
        chk("latest_error", v, 32'h2);
        rd(8'h08);
        chk("buffer", v, 32'h44);
        $display("latest error test done");
        frame(8'h55, 1'b1, 2'b11, 1'b0, 1'b0);
        wr(8'h04, 32'h0);
        rd(8'h04);
        chk("status_write", v, 32'h2);
        rd(8'h08);
        frame(8'h66, 1'b1, 2'b11, 1'b0, 1'b0);
        wr(8'h00, 32'h3c);
        wr(8'h00, mode(2'b11, 1'b1, 1'b0, 1'b0));
        rd(8'h04);
        chk("port_disable", v, 32'h0);
        frame(8'h77, 1'b1, 2'b11, 1'b0, 1'b0);
        wr(8'h00, 32'h9c);
        wr(8'h00, mode(2'b11, 1'b1, 1'b0, 1'b0));
        rd(8'h04);
        chk("rx_disable", v, 32'h0);
        $display("clear test done");
        wr(8'h14, 32'h2);
        wr(8'h10, 32'h3);
        rd(8'h10);
        chk("irq_status", v, 32'h0);
        frame(8'h12, 1'b1, 2'b11, 1'b0, 1'b1);
        chk("irq_masked", irq, 32'h0);
        rd(8'h10);
        chk("irq_status", v, 32'h1);
        rd(8'h08);
        frame(8'h34, 1'b1, 2'b11, 1'b1, 1'b1);
        chk("irq_level", irq, 32'h1);
        rd(8'h10);
        chk("irq_status", v, 32'h3);
        wr(8'h10, 32'h3);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("irq_cleared", irq, 32'h0);
        rd(8'hfc);
        chk("unmapped", v, 32'h0);
        $display("interrupt test done");
        results;
    end
endmodule
